// ### logic/cic_edge_det.sv
// cic_edge_det: selectable edge detector for the external pin
// assumes the pin already synchronous to pclk
`timescale 1ns/100ps
module cic_edge_det (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    input  wire logic rising,
    output logic      hit
);
    logic last_ff;
    logic arm_ff;

    // no edge before a first sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_ff <= 1'b0;
            arm_ff <= 1'b0;
        end else begin
            last_ff <= pin;
            arm_ff <= 1'b1;
        end
    end

    assign hit = arm_ff & (rising ? (pin & ~last_ff) : (~pin & last_ff));
endmodule // cic_edge_det

// ### logic/cic_flag_cell.sv
// cic_flag_cell: sticky event flags with software write
// assumes set pulses synchronous to pclk; a set beats a same-cycle clear
`timescale 1ns/100ps
module cic_flag_cell #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] set,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    output logic      [W-1:0] q
);
    logic [W-1:0] flag_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= '0;
        end else if (wr_en) begin
            flag_ff <= wr_data | set;
        end else begin
            flag_ff <= flag_ff | set;
        end
    end

    assign q = flag_ff;
endmodule // cic_flag_cell

// ### logic/cic_irq_ctrl.sv
// cic_irq_ctrl: interrupt controller of a small 8-bit cpu, apb slave
// assumes the core pulses cycle_tick once per instruction cycle and
// obeys flush, push, vector, pop and restore commands
//
// Behaviour
// - after reset every enable is clear until software sets them
// - a peripheral event reaches the cpu only with global, own and group enables; a core event needs global and own
// - flags set on their event whatever the enables are
// - taking an interrupt flushes, clears global enable, pushes pc, saves, vectors 0004h
// - events during the service routine only set flags
// - return_from_irq pops pc, restores context and sets global enable
// - pending interrupt is taken once global enable is set again
// - synchronous events reach the vector in three or four cycles
// - asynchronous events reach the vector in three to five cycles
// - external pin flag may set at any clock of the cycle
// - after wake the next instruction runs before any vectoring
// - external pin triggers on the edge chosen by ext_edge_select
// - valid edge sets ext_pin_irq_flag; vectors only with both enables
// - entry saves accumulator, status less two flags, bank, pointers, pc latch
// - shadow registers are read and written by software, restored on exit
// - core control register is read and write, holds five enables and three flags
// - peripheral_irq_enable gates all peripheral interrupts together
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
module cic_irq_ctrl (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    input  wire logic                   timer_zero_overflow,
    input  wire logic                   pin_change,
    input  wire logic                   ext_pin,
    input  wire logic [7:0]             periph_evt_one,
    input  wire logic [7:0]             periph_evt_two,
    input  wire cic_pkg::cic_core_req_t core_req,
    output cic_pkg::cic_core_cmd_t      core_cmd
);

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic        wr_acc;
    logic        rd_setup;
    logic        hit_map;
    logic        wr_ctrl;
    logic        wr_pen1;
    logic        wr_pen2;
    logic        wr_pflg1;
    logic        wr_pflg2;
    logic        wr_opt;
    logic        wr_shadow;
    logic [2:0]  shadow_idx;

    assign shadow_idx = paddr[4:2];
    assign wr_acc     = psel & penable & pwrite;
    assign rd_setup   = psel & ~penable & ~pwrite;
    assign wr_ctrl    = wr_acc & (paddr == cic_pkg::OFS_CORE_CTRL);
    assign wr_pen1    = wr_acc & (paddr == cic_pkg::OFS_PEN_ONE);
    assign wr_pen2    = wr_acc & (paddr == cic_pkg::OFS_PEN_TWO);
    assign wr_pflg1   = wr_acc & (paddr == cic_pkg::OFS_PFLG_ONE);
    assign wr_pflg2   = wr_acc & (paddr == cic_pkg::OFS_PFLG_TWO);
    assign wr_opt     = wr_acc & (paddr == cic_pkg::OFS_OPTION);
    assign wr_shadow  = wr_acc & (paddr[7:5] == cic_pkg::OFS_SHADOW[7:5])
                        & (paddr[1:0] == 2'b00);
    assign hit_map    = (paddr == cic_pkg::OFS_CORE_CTRL) | (paddr == cic_pkg::OFS_PEN_ONE)
                      | (paddr == cic_pkg::OFS_PEN_TWO) | (paddr == cic_pkg::OFS_PFLG_ONE)
                      | (paddr == cic_pkg::OFS_PFLG_TWO) | (paddr == cic_pkg::OFS_OPTION)
                      | ((paddr[7:5] == cic_pkg::OFS_SHADOW[7:5]) & (paddr[1:0] == 2'b00));

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_map;

    // ----------------------------------------------------------------
    // enables and option
    // ----------------------------------------------------------------
    logic                  glb_en_ff;
    logic [3:0]            en_ff;
    logic [7:0]            pen1_ff;
    logic [7:0]            pen2_ff;
    logic                  edge_sel_ff;
    cic_pkg::cic_state_t   state_ff;
    logic                  take;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            glb_en_ff <= cic_pkg::RST_CORE_CTRL[cic_pkg::BIT_GLB_EN];
        end else if (take) begin
            glb_en_ff <= 1'b0;
        end else if (core_req.return_from_irq) begin
            glb_en_ff <= 1'b1;
        end else if (wr_ctrl) begin
            glb_en_ff <= pwdata[cic_pkg::BIT_GLB_EN];
        end
    end

    // group and core enables, bits 6..3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff   <= cic_pkg::RST_CORE_CTRL[cic_pkg::BIT_GRP_EN:cic_pkg::BIT_PCIE];
            pen1_ff <= cic_pkg::RST_PERIPH;
            pen2_ff <= cic_pkg::RST_PERIPH;
        end else begin
            if (wr_ctrl) begin
                en_ff <= pwdata[cic_pkg::BIT_GRP_EN:cic_pkg::BIT_PCIE];
            end
            if (wr_pen1) begin
                pen1_ff <= pwdata[7:0] & cic_pkg::MASK_PEN_ONE;
            end
            if (wr_pen2) begin
                pen2_ff <= pwdata[7:0] & cic_pkg::MASK_PEN_TWO;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_sel_ff <= cic_pkg::RST_OPTION[cic_pkg::BIT_EDGE];
        end else if (wr_opt) begin
            edge_sel_ff <= pwdata[cic_pkg::BIT_EDGE];
        end
    end

    // ----------------------------------------------------------------
    // event flags
    // ----------------------------------------------------------------
    logic       ext_hit;
    logic [2:0] core_flags;
    logic [7:0] pflg1;
    logic [7:0] pflg2;

    // sampled each clock: any quarter may set it
    cic_edge_det u_ext_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (ext_pin),
        .rising  (edge_sel_ff),
        .hit     (ext_hit)
    );

    cic_flag_cell #(.W(3)) u_core_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .set     ({timer_zero_overflow, ext_hit, pin_change}),
        .wr_en   (wr_ctrl),
        .wr_data (pwdata[cic_pkg::BIT_T0IF:cic_pkg::BIT_PCIF]),
        .q       (core_flags)
    );

    cic_flag_cell #(.W(8)) u_pflg_one (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (periph_evt_one & cic_pkg::MASK_PEN_ONE),
        .wr_en   (wr_pflg1),
        .wr_data (pwdata[7:0] & cic_pkg::MASK_PEN_ONE),
        .q       (pflg1)
    );

    cic_flag_cell #(.W(8)) u_pflg_two (
        .pclk    (pclk),
        .presetn (presetn),
        .set     (periph_evt_two & cic_pkg::MASK_PEN_TWO),
        .wr_en   (wr_pflg2),
        .wr_data (pwdata[7:0] & cic_pkg::MASK_PEN_TWO),
        .q       (pflg2)
    );

    // ----------------------------------------------------------------
    // request gating
    // ----------------------------------------------------------------
    logic core_req_any;
    logic periph_any;
    logic enabled_any;
    logic pending;

    assign core_req_any = (en_ff[2] & core_flags[2]) | (en_ff[1] & core_flags[1])
                        | (en_ff[0] & core_flags[0]);
    assign periph_any   = en_ff[3] & (|(pen1_ff & pflg1) | |(pen2_ff & pflg2));
    assign enabled_any  = core_req_any | periph_any;
    assign pending      = glb_en_ff & enabled_any;

    // ----------------------------------------------------------------
    // sleep and wake
    // ----------------------------------------------------------------
    logic skip_ff;

    // hold off vectoring for the instruction after sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_ff <= 1'b0;
        end else if (core_req.sleeping) begin
            skip_ff <= 1'b1;
        end else if (core_req.cycle_tick) begin
            skip_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // entry sequencer
    // ----------------------------------------------------------------
    // sampled at a cycle tick: flush cycle, vector cycle, then vector code
    assign take = core_req.cycle_tick & (state_ff == cic_pkg::CIC_IDLE) & pending
                  & ~skip_ff & ~core_req.sleeping & ~core_req.return_from_irq;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= cic_pkg::CIC_IDLE;
        end else if (core_req.cycle_tick) begin
            unique case (state_ff)
                cic_pkg::CIC_IDLE: begin
                    if (take) begin
                        state_ff <= cic_pkg::CIC_FLUSH;
                    end
                end
                cic_pkg::CIC_FLUSH: begin
                    state_ff <= cic_pkg::CIC_VECT;
                end
                cic_pkg::CIC_VECT: begin
                    state_ff <= cic_pkg::CIC_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // shadow registers
    // ----------------------------------------------------------------
    logic [7:0]        shadow_ff [cic_pkg::SHADOW_REGS];
    cic_pkg::cic_ctx_t save_ctx;
    cic_pkg::cic_ctx_t shadow_ctx;

    assign save_ctx = '{acc:           core_req.ctx.acc,
                        status:        core_req.ctx.status & cic_pkg::STATUS_KEEP,
                        bank_select:   core_req.ctx.bank_select,
                        ind0_lo:       core_req.ctx.ind0_lo,
                        ind0_hi:       core_req.ctx.ind0_hi,
                        ind1_lo:       core_req.ctx.ind1_lo,
                        ind1_hi:       core_req.ctx.ind1_hi,
                        pc_high_latch: core_req.ctx.pc_high_latch};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < cic_pkg::SHADOW_REGS; i++) begin
                shadow_ff[i] <= 8'h00;
            end
        end else if (take) begin
            for (int i = 0; i < cic_pkg::SHADOW_REGS; i++) begin
                shadow_ff[i] <= save_ctx[8*(cic_pkg::SHADOW_REGS-1-i) +: 8];
            end
        end else if (wr_shadow) begin
            shadow_ff[shadow_idx] <= pwdata[7:0];
        end
    end

    always_comb begin
        shadow_ctx = '0;
        for (int i = 0; i < cic_pkg::SHADOW_REGS; i++) begin
            shadow_ctx[8*(cic_pkg::SHADOW_REGS-1-i) +: 8] = shadow_ff[i];
        end
        // watchdog and sleep flags stay as the core has them
        shadow_ctx.status = (shadow_ff[1] & cic_pkg::STATUS_KEEP)
                          | (core_req.ctx.status & ~cic_pkg::STATUS_KEEP);
    end

    // ----------------------------------------------------------------
    // core commands
    // ----------------------------------------------------------------
    cic_pkg::cic_core_cmd_t cmd_ff;
    cic_pkg::cic_core_cmd_t nxt_cmd;

    always_comb begin
        nxt_cmd             = '0;
        nxt_cmd.vector      = cic_pkg::IRQ_VECTOR;
        nxt_cmd.ctx         = cmd_ff.ctx;
        nxt_cmd.flush       = take;
        nxt_cmd.push_pc     = take;
        nxt_cmd.load_vector = core_req.cycle_tick & (state_ff == cic_pkg::CIC_FLUSH);
        nxt_cmd.pop_pc      = core_req.return_from_irq;
        nxt_cmd.restore     = core_req.return_from_irq;
        nxt_cmd.wake        = core_req.sleeping & enabled_any;
        if (core_req.return_from_irq) begin
            nxt_cmd.ctx = shadow_ctx;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff <= '0;
        end else begin
            cmd_ff <= nxt_cmd;
        end
    end

    assign core_cmd = cmd_ff;

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [7:0]  rd_byte;
    logic [31:0] prdata_ff;

    always_comb begin
        rd_byte = 8'h00;
        if (paddr == cic_pkg::OFS_CORE_CTRL) begin
            rd_byte = {glb_en_ff, en_ff, core_flags};
        end else if (paddr == cic_pkg::OFS_PEN_ONE) begin
            rd_byte = pen1_ff;
        end else if (paddr == cic_pkg::OFS_PEN_TWO) begin
            rd_byte = pen2_ff;
        end else if (paddr == cic_pkg::OFS_PFLG_ONE) begin
            rd_byte = pflg1;
        end else if (paddr == cic_pkg::OFS_PFLG_TWO) begin
            rd_byte = pflg2;
        end else if (paddr == cic_pkg::OFS_OPTION) begin
            rd_byte = {7'h00, edge_sel_ff};
        end else if (hit_map) begin
            rd_byte = shadow_ff[shadow_idx];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_ff <= {24'h00_0000, rd_byte};
        end
    end

    assign prdata = prdata_ff;

endmodule // cic_irq_ctrl

// ### logic/cic_pkg.sv
// cic_pkg: constants and carriers of the cpu interrupt controller
// assumes an apb master with 32-bit data and a core that reports cycle ticks
package cic_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CORE_CTRL  = 8'h00;
    localparam logic [7:0] OFS_PEN_ONE    = 8'h04;
    localparam logic [7:0] OFS_PEN_TWO    = 8'h08;
    localparam logic [7:0] OFS_PFLG_ONE   = 8'h0C;
    localparam logic [7:0] OFS_PFLG_TWO   = 8'h10;
    localparam logic [7:0] OFS_OPTION     = 8'h14;
    localparam logic [7:0] OFS_SHADOW     = 8'h20;
    localparam int         SHADOW_REGS    = 8;

    // ----------------------------------------------------------------
    // core control and option register fields
    // ----------------------------------------------------------------
    localparam int BIT_GLB_EN = 7;
    localparam int BIT_GRP_EN = 6;
    localparam int BIT_T0IE   = 5;
    localparam int BIT_EXTIE  = 4;
    localparam int BIT_PCIE   = 3;
    localparam int BIT_T0IF   = 2;
    localparam int BIT_EXTIF  = 1;
    localparam int BIT_PCIF   = 0;
    localparam int BIT_EDGE   = 0;

    localparam logic [7:0] RST_CORE_CTRL  = 8'h00;
    localparam logic [7:0] RST_PERIPH     = 8'h00;
    localparam logic [7:0] RST_OPTION     = 8'h01;
    localparam logic [7:0] MASK_PEN_ONE   = 8'hF1;
    localparam logic [7:0] MASK_PEN_TWO   = 8'h04;
    localparam logic [7:0] STATUS_KEEP    = 8'hE7;
    localparam logic [14:0] IRQ_VECTOR    = 15'h0004;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] status;
        logic [7:0] bank_select;
        logic [7:0] ind0_lo;
        logic [7:0] ind0_hi;
        logic [7:0] ind1_lo;
        logic [7:0] ind1_hi;
        logic [7:0] pc_high_latch;
    } cic_ctx_t;

    typedef struct packed {
        logic     cycle_tick;
        logic     return_from_irq;
        logic     sleeping;
        cic_ctx_t ctx;
    } cic_core_req_t;

    typedef struct packed {
        logic        flush;
        logic        push_pc;
        logic        load_vector;
        logic [14:0] vector;
        logic        pop_pc;
        logic        restore;
        cic_ctx_t    ctx;
        logic        wake;
    } cic_core_cmd_t;

    typedef enum logic [1:0] {
        CIC_IDLE,
        CIC_FLUSH,
        CIC_VECT
    } cic_state_t;

endpackage

// ### verification/cic_core_model.sv
// cic_core_model: processor core seen by the controller
// assumes the bench drives sleep, return and live context loads
`timescale 1ns/100ps
module cic_core_model (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   sleep_req,
    input wire logic                   ret_req,
    input wire logic                   ctx_load,
    input wire cic_pkg::cic_ctx_t      ctx_init,
    input wire cic_pkg::cic_core_cmd_t core_cmd,
    output cic_pkg::cic_core_req_t     core_req
);
    logic [1:0]        cnt_ff;
    cic_pkg::cic_ctx_t ctx_ff;
    // instruction clock stands still in sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_ff <= 2'h0;
        else if (!sleep_req) cnt_ff <= cnt_ff + 2'h1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ctx_ff <= '0;
        else if (core_cmd.restore) ctx_ff <= core_cmd.ctx;
        else if (ctx_load) ctx_ff <= ctx_init;
    end
    assign core_req = '{cycle_tick: (cnt_ff == 2'h3) && !sleep_req,
                        return_from_irq: ret_req, sleeping: sleep_req, ctx: ctx_ff};
endmodule // cic_core_model

// ### verification/cic_irq_props.sv
// cic_irq_props: port assertions of the interrupt controller
// assumes bind onto cic_irq_ctrl; core ticks four clocks apart
`timescale 1ns/100ps
module cic_irq_props (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pslverr,
    input wire cic_pkg::cic_core_req_t core_req,
    input wire cic_pkg::cic_core_cmd_t core_cmd
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_RESET_QUIET: assert property (!$past(presetn) |-> !core_cmd.flush)
        else $error("entry after reset");
    AST_TAKE_ON_TICK: assert property (core_cmd.flush |-> $past(core_req.cycle_tick))
        else $error("entry off tick");
    AST_NO_SLEEP_TAKE: assert property (core_req.sleeping |=> !core_cmd.flush)
        else $error("entry while sleeping");
    AST_FLUSH_PUSH: assert property (core_cmd.flush |-> core_cmd.push_pc)
        else $error("flush without push");
    AST_VECTOR: assert property (core_cmd.flush |=> !core_cmd.load_vector ##[1:8]
        (core_cmd.load_vector && core_cmd.vector == cic_pkg::IRQ_VECTOR))
        else $error("vector load wrong");
    AST_ONE_ENTRY: assert property (core_cmd.flush |=> !core_cmd.flush [*3])
        else $error("entry repeated");
    AST_RETURN: assert property (core_req.return_from_irq |=>
        core_cmd.pop_pc && core_cmd.restore)
        else $error("return not honoured");
    AST_WAKE: assert property (core_cmd.wake |-> $past(core_req.sleeping))
        else $error("wake while awake");
    AST_SLVERR: assert property (pslverr |-> psel && penable)
        else $error("slverr outside access");
    cover property (core_cmd.load_vector);
    cover property (core_cmd.restore);
    cover property (core_cmd.wake);
    cover property (pslverr);
endmodule // cic_irq_props

bind cic_irq_ctrl cic_irq_props u_cic_irq_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pslverr(pslverr), .core_req(core_req),
    .core_cmd(core_cmd));

// ### verification/testbench.sv
// testbench: directed scenarios for the interrupt controller
// assumes cic_irq_ctrl, cic_core_model and the bound checker
`timescale 1ns/100ps
module testbench;
    logic                   pclk = 1'b0;
    logic                   presetn = 1'b0;
    logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]             paddr = 8'h00, ev1 = 8'h00, ev2 = 8'h00;
    logic [31:0]            pwdata = 32'h0, prdata, rd;
    logic                   pready, pslverr, er;
    logic                   t0 = 1'b0, pc = 1'b0, ext = 1'b0;
    logic                   slp = 1'b0, ret = 1'b0, cld = 1'b0;
    cic_pkg::cic_ctx_t      ctx0 = '0;
    cic_pkg::cic_core_req_t core_req;
    cic_pkg::cic_core_cmd_t core_cmd;
    int                     n_errors = 0, samples_checked = 0, n_flush = 0, n_cyc = 0;

    cic_irq_ctrl u_cic_irq_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .timer_zero_overflow(t0),
        .pin_change(pc), .ext_pin(ext), .periph_evt_one(ev1), .periph_evt_two(ev2),
        .core_req(core_req), .core_cmd(core_cmd));
    cic_core_model u_cic_core_model (.pclk(pclk), .presetn(presetn), .sleep_req(slp),
        .ret_req(ret), .ctx_load(cld), .ctx_init(ctx0), .core_cmd(core_cmd),
        .core_req(core_req));

    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        n_cyc++;
        if (core_cmd.flush === 1'b1) n_flush++;
        if (n_cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic evt(input int k);
        @(posedge pclk);
        t0 <= (k == 0); pc <= (k == 1); ev1 <= (k == 2) ? 8'hFF : 8'h00;
        ev2 <= (k == 3) ? 8'hFF : 8'h00;
        @(posedge pclk);
        t0 <= 1'b0; pc <= 1'b0; ev1 <= 8'h00; ev2 <= 8'h00;
    endtask
    task automatic flush_in(input int n, input logic exp, input string what);
        int f0;
        f0 = n_flush;
        repeat (n) @(posedge pclk);
        chk({31'h0, n_flush != f0}, {31'h0, exp}, what);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask
    task automatic leave(input logic [31:0] exp_ctrl);
        @(posedge pclk) ret <= 1'b1;
        @(posedge pclk) ret <= 1'b0;
        rdchk(cic_pkg::OFS_CORE_CTRL, exp_ctrl, "enable after return");
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rdchk(cic_pkg::OFS_CORE_CTRL, 32'h00, "control reset");
        rdchk(cic_pkg::OFS_OPTION, 32'h01, "option reset");
        apb(1'b1, 8'h18, 32'hFF);
        chk(er, 1'b1, "unmapped write accepted");
        rdchk(8'h18, 32'h00, "unmapped read");
        apb(1'b1, cic_pkg::OFS_CORE_CTRL, 32'h78);
        rdchk(cic_pkg::OFS_CORE_CTRL, 32'h78, "control read back");
        $display("test reset done");
    endtask
    task automatic t_flags();
        for (int k = 0; k < 4; k++) evt(k);
        flush_in(8, 1'b0, "entry with enable clear");
        rdchk(cic_pkg::OFS_CORE_CTRL, 32'h7D, "core flags set");
        rdchk(cic_pkg::OFS_PFLG_ONE, 32'hF1, "flags one");
        rdchk(cic_pkg::OFS_PFLG_TWO, 32'h04, "flags two");
        apb(1'b1, cic_pkg::OFS_PFLG_ONE, 32'h0);
        apb(1'b1, cic_pkg::OFS_CORE_CTRL, 32'h80);
        apb(1'b1, cic_pkg::OFS_PEN_ONE, 32'h01);
        evt(2);
        flush_in(12, 1'b0, "no group enable");
        apb(1'b1, cic_pkg::OFS_CORE_CTRL, 32'hC0);
        flush_in(12, 1'b1, "pending not taken");
        rdchk(cic_pkg::OFS_CORE_CTRL, 32'h40, "enable not cleared");
        apb(1'b1, cic_pkg::OFS_PFLG_ONE, 32'h0);
        leave(32'hC0);
        $display("test flags done");
    endtask
    task automatic t_ext();
        apb(1'b1, cic_pkg::OFS_CORE_CTRL, 32'h00);
        for (int s = 1; s >= 0; s--) begin
            apb(1'b1, cic_pkg::OFS_OPTION, s);
            for (int i = 0; i < 2; i++) begin
                apb(1'b1, cic_pkg::OFS_CORE_CTRL, 32'h00);
                @(posedge pclk) ext <= ~ext;
                rdchk(cic_pkg::OFS_CORE_CTRL, {30'h0, ext != s[0], 1'b0}, "edge");
            end
        end
        apb(1'b1, cic_pkg::OFS_CORE_CTRL, 32'h90);
        @(posedge pclk) ext <= 1'b1;
        flush_in(12, 1'b0, "wrong edge taken");
        @(posedge pclk) ext <= 1'b0;
        flush_in(12, 1'b1, "pin edge not taken");
        rdchk(cic_pkg::OFS_CORE_CTRL, 32'h12, "pin flag in service");
        apb(1'b1, cic_pkg::OFS_CORE_CTRL, 32'h10);
        leave(32'h90);
        $display("test pin done");
    endtask
    task automatic t_entry();
        int c;
        apb(1'b1, cic_pkg::OFS_CORE_CTRL, 32'hA0);
        ctx0 = '{acc: 8'h11, status: 8'hFF, default: 8'h22};
        @(posedge pclk) cld <= 1'b1;
        @(posedge pclk) cld <= 1'b0;
        evt(0);
        c = 0;
        while (core_cmd.load_vector !== 1'b1 && c < 40) begin
            @(posedge pclk);
            c++;
        end
        chk({31'h0, c <= 16}, 32'h1, "vector latency");
        chk({17'h0, core_cmd.vector}, 32'h0004, "vector value");
        rdchk(8'h20, 32'h11, "saved accumulator");
        rdchk(8'h24, 32'hE7, "saved status");
        evt(0);
        flush_in(12, 1'b0, "nested entry");
        apb(1'b1, 8'h20, 32'h5A);
        ctx0.acc = 8'h33;
        @(posedge pclk) cld <= 1'b1;
        @(posedge pclk) cld <= 1'b0;
        apb(1'b1, cic_pkg::OFS_CORE_CTRL, 32'h20);
        leave(32'hA0);
        chk({24'h0, core_req.ctx.acc}, 32'h5A, "restored accumulator");
        $display("test entry done");
    endtask
    task automatic t_sleep();
        apb(1'b1, cic_pkg::OFS_CORE_CTRL, 32'h20);
        @(posedge pclk) slp <= 1'b1;
        evt(0);
        repeat (3) @(posedge pclk);
        chk(core_cmd.wake, 1'b1, "no wake request");
        apb(1'b1, cic_pkg::OFS_CORE_CTRL, 32'hA4);
        flush_in(8, 1'b0, "entry in sleep");
        @(posedge pclk) slp <= 1'b0;
        while (core_req.cycle_tick !== 1'b1) @(posedge pclk);
        flush_in(2, 1'b0, "entry on wake tick");
        flush_in(8, 1'b1, "no entry after wake");
        apb(1'b1, cic_pkg::OFS_CORE_CTRL, 32'h20);
        leave(32'hA0);
        $display("test sleep done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_flags();
        t_ext();
        t_entry();
        t_sleep();
        complete_run();
    end
endmodule // testbench
